// >>> shared/prgst_consts.svh
/*
 * constants of the programmable protection stage bank: sizes, timing,
 * register word addresses, field positions, reset values, source map.
 * assumes inclusion by bare name from package and design files.
 */
`ifndef PRGST_CONSTS_SVH
`define PRGST_CONSTS_SVH

// ==========================================================
// sizes
`define PRGST_NSTG        10
`define PRGST_NSLOT       30
`define PRGST_MEAS_N      256
`define PRGST_MULT_FRAC   8
`define PRGST_HYST_SHIFT  16

// ==========================================================
// timing
`define PRGST_CLK_HZ      50000000
`define PRGST_CYCLE_US    5000
`define PRGST_CYCLE_MS    5
`define PRGST_TICK_CYCLES (`PRGST_CLK_HZ / 1000000 * `PRGST_CYCLE_US)
`define PRGST_DLY_MS      40

// ==========================================================
// register word addresses and per-stage fields
`define PRGST_REG_CTRL    8'h00
`define PRGST_REG_STATUS  8'h01
`define PRGST_F_CFG       4'h0
`define PRGST_F_PICK      4'h1
`define PRGST_F_HYST      4'h2
`define PRGST_F_DLY       4'h3
`define PRGST_F_MULT      4'h4
`define PRGST_F_COND      4'h8
`define PRGST_F_EXPT      4'h9
`define PRGST_F_REMAIN    4'ha
`define PRGST_F_SCL0      4'hb
`define PRGST_F_SCL2      4'hd
`define PRGST_CTRL_ACT    0
`define PRGST_CTRL_NSTG   4
`define PRGST_CFG_EN      24
`define PRGST_CFG_MODE    25
`define PRGST_CFG_NSEL    27
`define PRGST_STAT_START  16

// ==========================================================
// reset values
`define PRGST_NSTG_RST    4'h1
`define PRGST_HYST_RST    16'h07ae
`define PRGST_MULT_RST    16'h0100
`define PRGST_PICK_RST    24'h000001

// ==========================================================
// measurement slot bases in the store
`define PRGST_SRC_CUR     8'h00
`define PRGST_SRC_SEQI    8'h46
`define PRGST_SRC_VOLT    8'h55
`define PRGST_SRC_POWER   8'h68
`define PRGST_SRC_IMPED   8'h7c
`define PRGST_SRC_ADMIT   8'had
`define PRGST_SRC_FREQ    8'hc9
`define PRGST_SRC_THERM   8'hcc
`define PRGST_SRC_RTD     8'hcf
`define PRGST_SRC_EXTRTD  8'hdf
`define PRGST_SRC_MA      8'he7
`define PRGST_SRC_ASC     8'heb

`endif

// >>> shared/prgst_pkg.sv
/*
 * types of the programmable protection stage bank.
 * assumes prgst_consts.svh on the include path.
 */
`include "prgst_consts.svh"

package prgst_pkg;

   // ==========================================================
   // encodings
   typedef enum logic [4:0] {
      COND_NORMAL   = 5'h01,
      COND_START    = 5'h02,
      COND_TRIP     = 5'h04,
      COND_BLOCKED  = 5'h08,
      COND_DISABLED = 5'h10
   } prgst_cond_t;

   typedef enum logic [1:0] {
      MODE_OVER  = 2'h0,
      MODE_UNDER = 2'h1,
      MODE_ROC   = 2'h2
   } prgst_mode_t;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'h1,
      SEQ_RUN  = 2'h2
   } prgst_seq_t;

   // ==========================================================
   // module states
   typedef struct packed {
      logic                   act;
      logic [3:0]             nstg;
      logic [9:0]             en;
      prgst_mode_t [9:0]      mode;
      logic [9:0][1:0]        nsel;
      logic [9:0][2:0][7:0]   src;
      logic [9:0][23:0]       pick;
      logic [9:0][15:0]       hyst;
      logic [9:0][15:0]       dly;
      logic [9:0][15:0]       mult;
      logic [9:0][15:0]       cnt;
      prgst_cond_t [9:0]      cond;
      logic [9:0]             start;
      logic [9:0]             trip;
      logic [29:0]            pu;
      logic [29:0][23:0]      prev;
      logic [29:0][23:0]      scl;
      prgst_seq_t             seq;
      logic [3:0]             s;
      logic [1:0]             k;
      logic                   pv;
      logic [3:0]             ps;
      logic [1:0]             pk;
      logic [31:0]            rdata;
   } prgst_main_t;

   typedef struct packed {
      logic [255:0][23:0] mem;
      logic [23:0]        out;
   } prgst_sel_t;

   typedef struct packed {
      logic [17:0] cnt;
      logic        tick;
   } prgst_tick_t;

endpackage

// >>> logic/prgst_tick.sv
/*
 * evaluation tick generator: one-cycle pulse every TICK_CYCLES clocks.
 * assumes one clock domain and TICK_CYCLES no larger than 2**18.
 */
`timescale 1ns/1ps
`include "prgst_consts.svh"

module prgst_tick #(
   parameter int unsigned TICK_CYCLES = `PRGST_TICK_CYCLES
) (
   // clock and reset
   input  wire logic i_clock,
   input  wire logic i_sys_rst,
   // tick
   output logic      o_tick
);

   prgst_pkg::prgst_tick_t st, nx;

   // ==========================================================
   // free-running divider
   always_comb begin
      nx = st;
      nx.tick = 1'b0;
      if (st.cnt == 18'(TICK_CYCLES - 1)) begin
         nx.cnt  = '0;
         nx.tick = 1'b1;
      end else begin
         nx.cnt = st.cnt + 18'h00001;
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end

   assign o_tick = st.tick;

   // ==========================================================
   // checks
   property p_tick_period;
      @(posedge i_clock) disable iff (i_sys_rst)
      o_tick |-> (st.cnt == '0) && ($past(st.cnt) == 18'(TICK_CYCLES - 1));
   endproperty
   a_tick_period: assert property (p_tick_period)
      else $error("tick pulse off the cycle period");

endmodule

// >>> logic/prgst_meas_sel.sv
/*
 * measurement store and scaler: producers write slots, one slot is read
 * per clock and multiplied by a signed 8.8 multiplier with saturation.
 * assumes producers on the same clock; result one cycle after request.
 */
`timescale 1ns/1ps
`include "prgst_consts.svh"

module prgst_meas_sel (
   // clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_sys_rst,
   // producer side
   input  wire logic        i_meas_wr,
   input  wire logic [7:0]  i_meas_idx,
   input  wire logic [23:0] i_meas_val,
   // selection
   input  wire logic [7:0]  i_sel_idx,
   input  wire logic [15:0] i_mult,
   output logic [23:0]      o_scaled
);

   prgst_pkg::prgst_sel_t st, nx;

   // saturate rather than wrap so a large fault never reads as small
   function automatic logic [23:0] scale(input logic [23:0] v,
                                         input logic [15:0] m);
      logic signed [39:0] p;
      p = 40'($signed(v)) * 40'($signed(m));
      p = p >>> `PRGST_MULT_FRAC;
      if (p > 40'sh00007fffff) begin
         scale = 24'h7fffff;
      end else if (p < -40'sh0000800000) begin
         scale = 24'h800000;
      end else begin
         scale = p[23:0];
      end
   endfunction

   // ==========================================================
   // store and scale
   always_comb begin
      nx = st;
      if (i_meas_wr) begin
         nx.mem[i_meas_idx] = i_meas_val;
      end
      nx.out = scale(st.mem[i_sel_idx], i_mult);
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end

   assign o_scaled = st.out;

endmodule

// >>> logic/prgst_top.sv
/*
 * bank of ten programmable protection stages with register port.
 * assumes measurement producers, block inputs and the register master
 * all run on i_clock; register reads answer one cycle later.
 */
`timescale 1ns/1ps
`include "prgst_consts.svh"

module prgst_top #(
   parameter int unsigned TICK_CYCLES = `PRGST_TICK_CYCLES
) (
   // clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_sys_rst,
   // register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wr_data,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [31:0]      o_rd_data,
   // measurement producers
   input  wire logic        i_meas_wr,
   input  wire logic [7:0]  i_meas_idx,
   input  wire logic [23:0] i_meas_val,
   // stage block inputs and outputs
   input  wire logic [9:0]  i_block,
   output logic [9:0]       o_start,
   output logic [9:0]       o_trip
);

   prgst_pkg::prgst_main_t st, nx;
   logic [9:0]  vis;
   logic [9:0]  live;
   logic        tick;
   logic [23:0] scaled;
   logic [31:0] rem0;

   // ==========================================================
   // helpers
   function automatic logic [31:0] to_ms(input logic [15:0] t);
      to_ms = 32'(t) * 32'(`PRGST_CYCLE_MS);
   endfunction

   function automatic logic [4:0] slot(input logic [3:0] s,
                                       input logic [1:0] k);
      slot = 5'(s * 3 + k);
   endfunction

   // band is |pick| * hyst / 2**16, so it follows setting changes
   function automatic logic pick_eval(input prgst_pkg::prgst_mode_t m,
                                      input logic [23:0] v,
                                      input logic [23:0] pv,
                                      input logic [23:0] pk,
                                      input logic [15:0] hy,
                                      input logic        was);
      logic signed [25:0] d;
      logic signed [25:0] lim;
      logic signed [25:0] band;
      logic [23:0]        mag;
      logic [39:0]        prod;
      mag  = pk[23] ? 24'(-pk) : pk;
      prod = 40'(mag) * 40'(hy);
      band = 26'(prod >> `PRGST_HYST_SHIFT);
      lim  = {{2{pk[23]}}, pk};
      d    = {{2{v[23]}}, v};
      if (m == prgst_pkg::MODE_ROC) begin
         d = d - {{2{pv[23]}}, pv};
         if (d < 0) begin
            d = -d;
         end
      end
      if (m == prgst_pkg::MODE_UNDER) begin
         pick_eval = was ? (d < lim + band) : (d < lim);
      end else begin
         pick_eval = was ? (d > lim - band) : (d > lim);
      end
   endfunction

   // ==========================================================
   // submodules
   prgst_tick #(
      .TICK_CYCLES (TICK_CYCLES)
   ) prgst_tick_i (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .o_tick    (tick)
   );

   // store covers every source group of the slot map
   prgst_meas_sel prgst_meas_sel_i (
      .i_clock    (i_clock),
      .i_sys_rst  (i_sys_rst),
      .i_meas_wr  (i_meas_wr),
      .i_meas_idx (i_meas_idx),
      .i_meas_val (i_meas_val),
      .i_sel_idx  (st.src[st.s][st.k]),
      .i_mult     (st.mult[st.s]),
      .o_scaled   (scaled)
   );

   // ==========================================================
   // visibility: count chosen only matters once activated
   always_comb begin
      for (int i = 0; i < `PRGST_NSTG; i++) begin
         vis[i] = st.act && (4'(i) < st.nstg);
      end
      live = vis & st.en;
      rem0 = to_ms(st.dly[0] - st.cnt[0]);
   end

   // ==========================================================
   // register port, sequencer and stage timers
   always_comb begin
      logic [3:0]  ws;
      logic [3:0]  f;
      logic [4:0]  ix;
      logic [15:0] nc;
      logic        any;
      logic        inuse;
      ws    = i_addr[7:4] - 4'h1;
      f     = i_addr[3:0];
      ix    = slot(st.ps, st.pk);
      nc    = '0;
      any   = 1'b0;
      inuse = 1'b0;
      nx    = st;
      nx.rdata = '0;
      nx.pv    = 1'b0;

      // writes land at once; the next tick uses them, timers keep going
      if (i_wr) begin
         if (i_addr == `PRGST_REG_CTRL) begin
            nx.act = i_wr_data[`PRGST_CTRL_ACT];
            nx.nstg = i_wr_data[`PRGST_CTRL_NSTG +: 4];
            if (nx.nstg == 4'h0) begin
               nx.nstg = 4'h1;
            end else if (nx.nstg > 4'(`PRGST_NSTG)) begin
               nx.nstg = 4'(`PRGST_NSTG);
            end
         end else if (i_addr[7:4] != 4'h0 && ws < 4'(`PRGST_NSTG)
                      && vis[ws]) begin
            case (f)
               `PRGST_F_CFG: begin
                  nx.src[ws] = i_wr_data[23:0];
                  nx.en[ws]  = i_wr_data[`PRGST_CFG_EN];
                  nx.mode[ws] = prgst_pkg::prgst_mode_t'(
                     i_wr_data[`PRGST_CFG_MODE +: 2]);
                  nx.nsel[ws] = i_wr_data[`PRGST_CFG_NSEL +: 2];
               end
               `PRGST_F_PICK: nx.pick[ws] = i_wr_data[23:0];
               `PRGST_F_HYST: nx.hyst[ws] = i_wr_data[15:0];
               `PRGST_F_DLY:  nx.dly[ws]  = i_wr_data[15:0];
               `PRGST_F_MULT: nx.mult[ws] = i_wr_data[15:0];
               default: ;
            endcase
         end
      end

      // reads: hidden stages and unmapped words give zero
      if (i_rd) begin
         if (i_addr == `PRGST_REG_CTRL) begin
            nx.rdata = {24'h000000, st.nstg, 3'h0, st.act};
         end else if (i_addr == `PRGST_REG_STATUS) begin
            nx.rdata = {6'h00, o_start, 6'h00, o_trip};
         end else if (i_addr[7:4] != 4'h0 && ws < 4'(`PRGST_NSTG)
                      && vis[ws]) begin
            case (f)
               `PRGST_F_CFG: nx.rdata = {3'h0, st.nsel[ws],
                                         st.mode[ws], st.en[ws],
                                         st.src[ws]};
               `PRGST_F_PICK: nx.rdata = {{8{st.pick[ws][23]}},
                                          st.pick[ws]};
               `PRGST_F_HYST: nx.rdata = {16'h0000, st.hyst[ws]};
               `PRGST_F_DLY:  nx.rdata = {16'h0000, st.dly[ws]};
               `PRGST_F_MULT: nx.rdata = {16'h0000, st.mult[ws]};
               `PRGST_F_COND: nx.rdata = live[ws]
                  ? {27'h0, st.cond[ws]}
                  : {27'h0, prgst_pkg::COND_DISABLED};
               `PRGST_F_EXPT: nx.rdata = live[ws]
                  ? to_ms(st.dly[ws]) : 32'h0;
               `PRGST_F_REMAIN: nx.rdata =
                  (live[ws] && st.cond[ws] == prgst_pkg::COND_START)
                  ? to_ms(st.dly[ws] - st.cnt[ws]) : 32'h0;
               `PRGST_F_SCL0, 4'hc, `PRGST_F_SCL2: begin
                  ix = slot(ws, 2'(f - `PRGST_F_SCL0));
                  nx.rdata = {{8{st.scl[ix][23]}}, st.scl[ix]};
                  ix = slot(st.ps, st.pk);
               end
               default: nx.rdata = '0;
            endcase
         end
      end

      // sequencer: one slot per clock, 30 clocks per tick
      case (st.seq)
         prgst_pkg::SEQ_IDLE: begin
            if (tick) begin
               nx.seq = prgst_pkg::SEQ_RUN;
               nx.s   = 4'h0;
               nx.k   = 2'h0;
            end
         end
         prgst_pkg::SEQ_RUN: begin
            nx.pv = 1'b1;
            nx.ps = st.s;
            nx.pk = st.k;
            if (st.k == 2'h2) begin
               nx.k = 2'h0;
               if (st.s == 4'(`PRGST_NSTG - 1)) begin
                  nx.seq = prgst_pkg::SEQ_IDLE;
               end else begin
                  nx.s = st.s + 4'h1;
               end
            end else begin
               nx.k = st.k + 2'h1;
            end
         end
         default: nx.seq = prgst_pkg::SEQ_IDLE;
      endcase

      // compare the scaled value that came back for slot (ps, pk)
      if (st.pv) begin
         inuse = (st.nsel[st.ps] == 2'h0) ? (st.pk == 2'h0)
                                          : (st.pk < st.nsel[st.ps]);
         if (vis[st.ps] && inuse) begin
            nx.scl[ix]  = scaled;
            nx.prev[ix] = scaled;
         end
         if (live[st.ps] && inuse && !i_block[st.ps]) begin
            nx.pu[ix] = pick_eval(st.mode[st.ps], scaled,
                                  st.prev[ix], st.pick[st.ps],
                                  st.hyst[st.ps], st.pu[ix]);
         end else begin
            nx.pu[ix] = 1'b0;
         end
         if (st.pk == 2'h2) begin
            any = |nx.pu[slot(st.ps, 2'h0) +: 3];
            nc  = (st.cnt[st.ps] == 16'hffff) ? st.cnt[st.ps]
                                              : st.cnt[st.ps] + 16'h0001;
            nx.start[st.ps] = 1'b0;
            nx.trip[st.ps]  = 1'b0;
            nx.cnt[st.ps]   = '0;
            if (!live[st.ps]) begin
               nx.cond[st.ps] = prgst_pkg::COND_DISABLED;
            end else if (i_block[st.ps]) begin
               nx.cond[st.ps] = prgst_pkg::COND_BLOCKED;
            end else if (any) begin
               nx.cnt[st.ps]   = nc;
               nx.start[st.ps] = 1'b1;
               nx.trip[st.ps]  = (nc >= st.dly[st.ps]);
               nx.cond[st.ps]  = (nc >= st.dly[st.ps])
                  ? prgst_pkg::COND_TRIP : prgst_pkg::COND_START;
            end else begin
               nx.cond[st.ps] = prgst_pkg::COND_NORMAL;
            end
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st      <= '0;
         st.nstg <= `PRGST_NSTG_RST;
         st.hyst <= {`PRGST_NSTG{`PRGST_HYST_RST}};
         st.mult <= {`PRGST_NSTG{`PRGST_MULT_RST}};
         st.pick <= {`PRGST_NSTG{`PRGST_PICK_RST}};
         st.dly  <= {`PRGST_NSTG{16'(`PRGST_DLY_MS / `PRGST_CYCLE_MS)}};
         st.cond <= {`PRGST_NSTG{prgst_pkg::COND_DISABLED}};
         st.seq  <= prgst_pkg::SEQ_IDLE;
      end else begin
         st <= nx;
      end
   end

   // outputs drop at once when a stage is hidden or disabled
   assign o_start   = st.start & live;
   assign o_trip    = st.trip & live;
   assign o_rd_data = st.rdata;

   // ==========================================================
   // checks
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);

   property p_dis_cond;
      st.pv && st.ps == 4'h0 && st.pk == 2'h2 && !live[0]
      |=> st.cond[0] == prgst_pkg::COND_DISABLED;
   endproperty
   a_dis_cond: assert property (p_dis_cond)
      else $error("disabled stage not reported disabled");

   property p_hidden_read;
      i_rd && i_addr == {4'ha, `PRGST_F_COND} && !vis[9]
      |=> o_rd_data == 32'h0;
   endproperty
   a_hidden_read: assert property (p_hidden_read)
      else $error("hidden stage visible on read");

   property p_trip_delay;
      $rose(st.trip[0]) |-> st.cnt[0] >= st.dly[0] && $past(st.pv);
   endproperty
   a_trip_delay: assert property (p_trip_delay)
      else $error("trip before the delay count");

   property p_start_first;
      $rose(st.trip[0]) && st.dly[0] > 16'h0001 |-> $past(st.start[0]);
   endproperty
   a_start_first: assert property (p_start_first)
      else $error("trip without preceding start");

   property p_cond_onehot;
      $onehot(st.cond[0]) && $onehot(st.cond[9]);
   endproperty
   a_cond_onehot: assert property (p_cond_onehot)
      else $error("condition code not one of five");

   property p_remain_read;
      i_rd && i_addr == {4'h1, `PRGST_F_REMAIN} && live[0]
      && st.cond[0] == prgst_pkg::COND_START
      |=> o_rd_data == $past(rem0);
   endproperty
   a_remain_read: assert property (p_remain_read)
      else $error("time remaining read wrong");

   property p_enable_gate;
      tick && !st.en[0] && !i_wr
      |-> ##5 (st.cond[0] == prgst_pkg::COND_DISABLED || st.en[0]);
   endproperty
   a_enable_gate: assert property (p_enable_gate)
      else $error("unenabled stage evaluated");

   property p_latency;
      tick |-> ##32 (st.seq == prgst_pkg::SEQ_IDLE && !st.pv);
   endproperty
   a_latency: assert property (p_latency)
      else $error("evaluation pass did not finish in 32 cycles");

endmodule

// >>> verif/prgst_meas_src.sv
/*
 * measurement producer model: writes one slot per call.
 * assumes put is called just after a rising edge of i_clock.
 */
`timescale 1ns/1ps
module prgst_meas_src (
   // clock
   input  wire logic   i_clock,
   // producer side
   output logic        o_meas_wr,
   output logic [7:0]  o_meas_idx,
   output logic [23:0] o_meas_val
);
   // idle until the first put, so the store never sees an unknown strobe
   initial begin
      o_meas_wr  = 1'b0;
      o_meas_idx = 8'h00;
      o_meas_val = 24'h000000;
   end
   // one-clock pulse; value inverted after it so a stale read shows up
   task automatic put(input logic [7:0] idx, input logic [23:0] val);
      @(posedge i_clock);
      o_meas_wr  <= 1'b1;
      o_meas_idx <= idx;
      o_meas_val <= val;
      @(posedge i_clock);
      o_meas_wr  <= 1'b0;
      o_meas_val <= ~val;
   endtask
endmodule

// >>> verif/prgst_top_bench.sv
/*
 * bench for the stage bank: register and measurement sequences.
 * assumes TICK_CYCLES of 64; phase is tracked by a local cycle count.
 */
`timescale 1ns/1ps
module prgst_top_bench;
   localparam int TK = 64;
   logic        i_clock, i_sys_rst, i_wr, i_rd;
   logic        i_meas_wr;
   logic [7:0]  i_addr, i_meas_idx;
   logic [31:0] i_wr_data, o_rd_data;
   logic [23:0] i_meas_val;
   logic [9:0]  i_block, o_start, o_trip;
   int          n_fail, n_checks, cyc;

   prgst_top #(.TICK_CYCLES(TK)) prgst_top_i (.i_clock(i_clock),
      .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
      .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
      .i_meas_wr(i_meas_wr), .i_meas_idx(i_meas_idx),
      .i_meas_val(i_meas_val), .i_block(i_block), .o_start(o_start),
      .o_trip(o_trip));
   prgst_meas_src prgst_meas_src_i (.i_clock(i_clock),
      .o_meas_wr(i_meas_wr), .o_meas_idx(i_meas_idx),
      .o_meas_val(i_meas_val));

   // ==========================================================
   // clock and phase count
   initial begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end
   always @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cyc <= 0;
      end else begin
         cyc <= cyc + 1;
      end
   end

   // ==========================================================
   // tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_wr      <= 1'b1;
      i_addr    <= a;
      i_wr_data <= d;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe, so sample there
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      @(posedge i_clock);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1;
      chk(o_rd_data, e);
   endtask
   // park in the quiet part of the period, after all stages updated
   task automatic ph();
      int n;
      n = 0;
      @(posedge i_clock);
      while (cyc % TK != 44 && n < 200) begin
         @(posedge i_clock);
         n++;
      end
      if (n >= 200) begin
         n_fail++;
         end_sim();
      end
   endtask
   task automatic end_sim();
      $display("checks=%0d fails=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      i_sys_rst = 1'b1;
      {i_wr, i_rd, i_addr, i_wr_data, i_block} = '0;
      n_fail = 0;
      n_checks = 0;
      repeat (20) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      rdc(8'h00, 32'h10);
      rdc(8'h18, 32'h0);
      rdc(8'hf8, 32'h0);
      wr(8'h00, 32'h21);
      rdc(8'h18, 32'h10);
      rdc(8'h38, 32'h0);
      rdc(8'ha8, 32'h0);
      rdc(8'h19, 32'h0);
      rdc(8'h12, 32'h7ae);
      ph();
      prgst_meas_src_i.put(8'h00, 24'h96);
      wr(8'h11, 32'h64);
      wr(8'h13, 32'h2);
      wr(8'h10, 32'h01000000);
      ph();
      rdc(8'h18, 32'h2);
      rdc(8'h1a, 32'h5);
      rdc(8'h19, 32'ha);
      rdc(8'h1b, 32'h96);
      chk({o_trip, o_start}, 32'h1);
      ph();
      rdc(8'h18, 32'h4);
      rdc(8'h01, 32'h00010001);
      prgst_meas_src_i.put(8'h00, 24'h63);
      ph();
      rdc(8'h18, 32'h4);
      prgst_meas_src_i.put(8'h00, 24'h62);
      ph();
      rdc(8'h18, 32'h1);
      chk({o_trip, o_start}, 32'h0);
      prgst_meas_src_i.put(8'h00, 24'h96);
      wr(8'h14, 32'h80);
      ph();
      rdc(8'h1b, 32'h4b);
      rdc(8'h18, 32'h1);
      wr(8'h14, 32'h100);
      i_block <= 10'h001;
      ph();
      rdc(8'h18, 32'h8);
      chk({22'h0, o_start}, 32'h0);
      i_block <= 10'h000;
      prgst_meas_src_i.put(8'h46, 24'h0a);
      wr(8'h21, 32'h32);
      wr(8'h20, 32'h03000046);
      ph();
      rdc(8'h28, 32'h2);
      chk({22'h0, o_start}, 32'h3);
      wr(8'h10, 32'h0);
      #1;
      chk({22'h0, o_start}, 32'h2);
      wr(8'h20, 32'h05000046);
      ph();
      rdc(8'h28, 32'h1);
      rdc(8'h18, 32'h10);
      prgst_meas_src_i.put(8'h46, 24'hc8);
      ph();
      rdc(8'h28, 32'h2);
      end_sim();
   end
endmodule
